// ---- rtl/dlwm_pkg.sv ----
package dlwm_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned DLWM_DW = 32;
  localparam int unsigned DLWM_AW = 8;
  localparam int unsigned DLWM_NCMP = 7;
  localparam int unsigned DLWM_NSEL = 4;

  // ----------------------------------------------------------------
  // Comparator slots (also warning flag bit positions)
  // ----------------------------------------------------------------
  localparam int unsigned SLOT_CUR_LOW = 0;
  localparam int unsigned SLOT_CUR_HIGH = 1;
  localparam int unsigned SLOT_FREQ_LOW = 2;
  localparam int unsigned SLOT_FREQ_HIGH = 3;
  localparam int unsigned SLOT_REF_LOW = 4;
  localparam int unsigned SLOT_REF_HIGH = 5;
  localparam int unsigned SLOT_FB_LOW = 6;

  // Slots that fire when the value is below the limit
  localparam logic [DLWM_NCMP-1:0] SLOT_BELOW = 7'h55;
  // Slots fed by the reference
  localparam logic [DLWM_NCMP-1:0] SLOT_REF_MASK = 7'h30;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [DLWM_AW-1:0] OFF_CTRL = 8'h00;
  localparam logic [DLWM_AW-1:0] OFF_THR_BASE = 8'h04;
  localparam logic [DLWM_AW-1:0] OFF_OUT_SEL = 8'h20;
  localparam logic [DLWM_AW-1:0] OFF_STATUS = 8'h24;
  localparam logic [DLWM_AW-1:0] OFF_IRQ_STAT = 8'h28;
  localparam logic [DLWM_AW-1:0] OFF_IRQ_MASK = 8'h2c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_ACTION_BIT = 0;
  localparam int unsigned CTRL_TRIP_CLR_BIT = 1;
  localparam int unsigned STATUS_ARMED_BIT = 8;
  localparam int unsigned STATUS_TRIP_BIT = 9;
  localparam int unsigned IRQ_TRIP_BIT = 7;
  localparam int unsigned SEL_W = 3;
  localparam int unsigned SEL_STRIDE = 4;

  // No-load action codes
  localparam logic ACTION_TRIP = 1'h0;
  localparam logic ACTION_WARNING = 1'h1;

  // ----------------------------------------------------------------
  // Reset values (limits in milli units, signed)
  // ----------------------------------------------------------------
  localparam logic ACTION_RST = ACTION_WARNING;
  localparam logic [15:0] OUT_SEL_RST = 16'h0000;
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;
  // 0.0 A
  localparam logic signed [DLWM_DW-1:0] CUR_LOW_RST = 32'h00000000;
  // Upper end of the current range
  localparam logic signed [DLWM_DW-1:0] CUR_HIGH_RST = 32'h7fffffff;
  localparam logic signed [DLWM_DW-1:0] FREQ_LOW_RST = 32'h00000000;
  // 120.0 Hz
  localparam logic signed [DLWM_DW-1:0] FREQ_HIGH_RST = 32'h0001d4c0;
  // -999,999.999
  localparam logic signed [DLWM_DW-1:0] REF_LOW_RST = 32'hc4653601;
  // 999,999.999
  localparam logic signed [DLWM_DW-1:0] REF_HIGH_RST = 32'h3b9ac9ff;
  localparam logic signed [DLWM_DW-1:0] FB_LOW_RST = 32'hc4653601;

  localparam logic signed [DLWM_DW-1:0] THR_RST [DLWM_NCMP] = '{
    CUR_LOW_RST, CUR_HIGH_RST, FREQ_LOW_RST, FREQ_HIGH_RST,
    REF_LOW_RST, REF_HIGH_RST, FB_LOW_RST
  };

endpackage

// ---- rtl/dlwm_cmp_if.sv ----
`timescale 1ns/10ps
interface dlwm_cmp_if;
  import dlwm_pkg::*;

  logic signed [DLWM_DW-1:0] value [DLWM_NCMP];
  logic signed [DLWM_DW-1:0] limit [DLWM_NCMP];
  logic [DLWM_NCMP-1:0] below;
  logic [DLWM_NCMP-1:0] hit;

  modport ctl (
    output value,
    output limit,
    output below,
    input hit
  );

  modport cmp (
    input value,
    input limit,
    input below,
    output hit
  );

endinterface

// ---- rtl/dlwm_cmp.sv ----
`timescale 1ns/10ps
module dlwm_cmp
  import dlwm_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  dlwm_cmp_if.cmp cmp_if
);

  logic [DLWM_NCMP-1:0] hit_q;

  // ----------------------------------------------------------------
  // One registered comparison per slot
  // ----------------------------------------------------------------
  for (genvar i = 0; i < DLWM_NCMP; i++)
  begin : g_cmp
    logic hit_d;
    assign hit_d = cmp_if.below[i] ? (cmp_if.value[i] < cmp_if.limit[i])
                                   : (cmp_if.value[i] > cmp_if.limit[i]);
    always_ff @(posedge ref_clk_i)
    begin
      if (!rst_n_i)
        hit_q[i] <= 1'b0;
      else
        hit_q[i] <= hit_d;
    end
  end

  assign cmp_if.hit = hit_q;

endmodule

// ---- rtl/dlwm_top.sv ----
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
// Functional notes
// - Current below low limit with warning action raises low-current warning.
// - Current below low limit with trip action trips the drive instead.
// - Low-current limit resets to zero and is capped at the high-current limit.
// - Current above high limit raises high-current warning.
// - Warnings idle while stopped and during the ramp after a start; armed once frequency reaches reference.
// - Any warning can be routed to the signal outputs and relay outputs.
// - Output frequency below low limit raises low-frequency warning.
// - Output frequency above high limit raises high-frequency warning; resets 120.0 Hz.
// - Reference below low limit raises low-reference warning; resets most negative.
// - Reference above high limit raises high-reference warning; resets largest.
// - Reference warnings only with remote reference selected, else suppressed.
module dlwm_top
  import dlwm_pkg::*;
#(
  parameter int unsigned DW = DLWM_DW,
  parameter int unsigned AW = DLWM_AW
)
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [DW-1:0] rd_data_o,
  input wire logic signed [DW-1:0] motor_current_i,
  input wire logic signed [DW-1:0] output_freq_i,
  input wire logic signed [DW-1:0] freq_reference_i,
  input wire logic signed [DW-1:0] remote_reference_i,
  input wire logic signed [DW-1:0] feedback_i,
  input wire logic remote_ref_sel_i,
  input wire logic run_i,
  output logic low_current_warning_o,
  output logic high_current_warning_o,
  output logic low_frequency_warning_o,
  output logic high_frequency_warning_o,
  output logic low_reference_warning_o,
  output logic high_reference_warning_o,
  output logic low_feedback_warning_o,
  output logic [1:0] signal_out_o,
  output logic [1:0] relay_out_o,
  output logic trip_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [AW-1:0] a, input logic [AW-1:0] off);
    addr_hit = (a == off);
  endfunction

  function automatic logic sel_flag(input logic [SEL_W-1:0] code,
                                    input logic [DLWM_NCMP-1:0] flags);
    logic [SEL_W-1:0] idx;
    idx = code - 3'h1;
    sel_flag = (code != 3'h0) && flags[idx];
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic action_q;
  logic [15:0] out_sel_q;
  logic [7:0] irq_mask_q;
  logic [7:0] irq_stat_q;
  logic [7:0] irq_stat_d;
  logic signed [DW-1:0] thr_q [DLWM_NCMP];
  logic signed [DW-1:0] thr_wr [DLWM_NCMP];
  logic armed_q;
  logic armed_d;
  logic [DLWM_NCMP-1:0] flags_q;
  logic [DLWM_NCMP-1:0] flags_d;
  logic [DLWM_NCMP-1:0] flags_prev_q;
  logic trip_q;
  logic trip_prev_q;
  logic trip_set;
  logic trip_clr;
  logic [1:0] signal_out_q;
  logic [1:0] relay_out_q;
  logic [DW-1:0] rd_data_q;
  logic [DW-1:0] rd_mux;
  logic [DW-1:0] thr_rd;
  logic [7:0] irq_events;
  logic wr_ctrl;
  logic wr_out_sel;
  logic wr_irq_stat;
  logic wr_irq_mask;
  logic rd_ctrl;
  logic rd_out_sel;
  logic rd_status;
  logic rd_irq_stat;
  logic rd_irq_mask;
  logic [DLWM_NSEL-1:0] route_d;

  dlwm_cmp_if cmp_bus ();

  dlwm_cmp dlwm_cmp_inst (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .cmp_if(cmp_bus)
  );

  // ----------------------------------------------------------------
  // Comparator wiring
  // ----------------------------------------------------------------
  assign cmp_bus.value[SLOT_CUR_LOW] = motor_current_i;
  assign cmp_bus.value[SLOT_CUR_HIGH] = motor_current_i;
  assign cmp_bus.value[SLOT_FREQ_LOW] = output_freq_i;
  assign cmp_bus.value[SLOT_FREQ_HIGH] = output_freq_i;
  assign cmp_bus.value[SLOT_REF_LOW] = remote_reference_i;
  assign cmp_bus.value[SLOT_REF_HIGH] = remote_reference_i;
  assign cmp_bus.value[SLOT_FB_LOW] = feedback_i;
  assign cmp_bus.below = SLOT_BELOW;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  assign wr_ctrl = wr_en_i && addr_hit(addr_i, OFF_CTRL);
  assign wr_out_sel = wr_en_i && addr_hit(addr_i, OFF_OUT_SEL);
  assign wr_irq_stat = wr_en_i && addr_hit(addr_i, OFF_IRQ_STAT);
  assign wr_irq_mask = wr_en_i && addr_hit(addr_i, OFF_IRQ_MASK);
  assign trip_clr = wr_ctrl && wr_data_i[CTRL_TRIP_CLR_BIT];

  // ----------------------------------------------------------------
  // Threshold registers
  // ----------------------------------------------------------------
  for (genvar i = 0; i < DLWM_NCMP; i++)
  begin : g_thr
    localparam logic [AW-1:0] OFF = AW'(OFF_THR_BASE + 4 * i);
    logic signed [DW-1:0] wv;
    logic wr_hit;
    assign wv = signed'(wr_data_i);
    assign wr_hit = wr_en_i && addr_hit(addr_i, OFF);
    // Paired low limits are capped at their high partner, high limits floored; the feedback low limit is free
    if (i == SLOT_FB_LOW)
    begin : g_free
      assign thr_wr[i] = wv;
    end
    else if (i == SLOT_CUR_LOW)
    begin : g_cur_low
      // A negative current limit could never fire, so it is floored at zero
      assign thr_wr[i] = (wv > thr_q[i+1]) ? thr_q[i+1] : ((wv < 0) ? '0 : wv);
    end
    else if ((i % 2) == 0)
    begin : g_low
      assign thr_wr[i] = (wv > thr_q[i+1]) ? thr_q[i+1] : wv;
    end
    else
    begin : g_high
      assign thr_wr[i] = (wv < thr_q[i-1]) ? thr_q[i-1] : wv;
    end
    assign cmp_bus.limit[i] = thr_q[i];
    always_ff @(posedge ref_clk_i)
    begin
      if (!rst_n_i)
        thr_q[i] <= THR_RST[i];
      else if (wr_hit)
        thr_q[i] <= thr_wr[i];
    end
  end

  // ----------------------------------------------------------------
  // Arming and warning flags
  // ----------------------------------------------------------------
  // Armed once at reference after a start; any stop drops it at once
  assign armed_d = run_i && (armed_q || (output_freq_i >= freq_reference_i));

  assign flags_d = armed_q ?
    (cmp_bus.hit
     & ~(remote_ref_sel_i ? 7'h00 : SLOT_REF_MASK)
     & ~((action_q == ACTION_WARNING) ? 7'h00 : 7'h01))
    : 7'h00;

  // Trip stays latched after the current recovers, until software clears it
  assign trip_set = armed_q && cmp_bus.hit[SLOT_CUR_LOW] && (action_q == ACTION_TRIP);

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      armed_q <= 1'b0;
      flags_q <= '0;
      flags_prev_q <= '0;
      trip_q <= 1'b0;
      trip_prev_q <= 1'b0;
    end
    else
    begin
      armed_q <= armed_d;
      flags_q <= flags_d;
      flags_prev_q <= flags_q;
      trip_q <= trip_set || (trip_q && !trip_clr);
      trip_prev_q <= trip_q;
    end
  end

  // ----------------------------------------------------------------
  // Output routing
  // ----------------------------------------------------------------
  for (genvar j = 0; j < DLWM_NSEL; j++)
  begin : g_route
    assign route_d[j] = sel_flag(out_sel_q[SEL_STRIDE*j +: SEL_W], flags_q);
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      signal_out_q <= '0;
      relay_out_q <= '0;
    end
    else
    begin
      {relay_out_q, signal_out_q} <= route_d;
    end
  end

  // ----------------------------------------------------------------
  // Control and interrupt registers
  // ----------------------------------------------------------------
  // Delayed copies turn flag and trip rises into one-cycle events
  assign irq_events = {trip_q && !trip_prev_q, flags_q & ~flags_prev_q};
  // A new event beats a write-one clear in the same cycle
  assign irq_stat_d = irq_events | (irq_stat_q & ~(wr_irq_stat ? wr_data_i[7:0] : 8'h00));

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      action_q <= ACTION_RST;
      out_sel_q <= OUT_SEL_RST;
      irq_mask_q <= IRQ_MASK_RST;
      irq_stat_q <= '0;
    end
    else
    begin
      if (wr_ctrl)
        action_q <= wr_data_i[CTRL_ACTION_BIT];
      if (wr_out_sel)
        out_sel_q <= wr_data_i[15:0] & 16'h7777;
      if (wr_irq_mask)
        irq_mask_q <= wr_data_i[7:0];
      irq_stat_q <= irq_stat_d;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb
  begin
    thr_rd = '0;
    for (int k = 0; k < DLWM_NCMP; k++)
    begin
      if (addr_hit(addr_i, AW'(OFF_THR_BASE + 4 * k)))
        thr_rd = thr_q[k];
    end
  end

  assign rd_ctrl = addr_hit(addr_i, OFF_CTRL);
  assign rd_out_sel = addr_hit(addr_i, OFF_OUT_SEL);
  assign rd_status = addr_hit(addr_i, OFF_STATUS);
  assign rd_irq_stat = addr_hit(addr_i, OFF_IRQ_STAT);
  assign rd_irq_mask = addr_hit(addr_i, OFF_IRQ_MASK);

  assign rd_mux =
    rd_ctrl ? {31'h0, action_q} :
    rd_out_sel ? {16'h0, out_sel_q} :
    rd_status ? {22'h0, trip_q, armed_q, 1'h0, flags_q} :
    rd_irq_stat ? {24'h0, irq_stat_q} :
    rd_irq_mask ? {24'h0, irq_mask_q} :
    thr_rd;

  // Data stand only in the cycle after a read strobe, zero otherwise
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      rd_data_q <= '0;
    else
      rd_data_q <= rd_en_i ? rd_mux : '0;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_data_o = rd_data_q;
  assign low_current_warning_o = flags_q[SLOT_CUR_LOW];
  assign high_current_warning_o = flags_q[SLOT_CUR_HIGH];
  assign low_frequency_warning_o = flags_q[SLOT_FREQ_LOW];
  assign high_frequency_warning_o = flags_q[SLOT_FREQ_HIGH];
  assign low_reference_warning_o = flags_q[SLOT_REF_LOW];
  assign high_reference_warning_o = flags_q[SLOT_REF_HIGH];
  assign low_feedback_warning_o = flags_q[SLOT_FB_LOW];
  assign signal_out_o = signal_out_q;
  assign relay_out_o = relay_out_q;
  assign trip_o = trip_q;
  // Level interrupt: high while any unmasked status bit is set
  assign irq_o = |(irq_stat_q & irq_mask_q);

endmodule

// ---- verification/dlwm_properties.sv ----
`timescale 1ns/10ps
module dlwm_properties
  import dlwm_pkg::*;
#(
  parameter int unsigned DW = DLWM_DW,
  parameter int unsigned AW = DLWM_AW
)
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [DW-1:0] rd_data_o,
  input wire logic remote_ref_sel_i,
  input wire logic run_i,
  input wire logic low_current_warning_o,
  input wire logic high_current_warning_o,
  input wire logic low_frequency_warning_o,
  input wire logic high_frequency_warning_o,
  input wire logic low_reference_warning_o,
  input wire logic high_reference_warning_o,
  input wire logic low_feedback_warning_o,
  input wire logic trip_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  wire [6:0] flags = {low_feedback_warning_o, high_reference_warning_o,
    low_reference_warning_o, high_frequency_warning_o, low_frequency_warning_o,
    high_current_warning_o, low_current_warning_o};
  wire trip_clear = wr_en_i && addr_i == OFF_CTRL && wr_data_i[CTRL_TRIP_CLR_BIT];
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence stopped_s;
    !run_i ##1 !run_i;
  endsequence
  sequence local_ref_s;
    !remote_ref_sel_i [*3];
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  stopped_quiet_a: assert property (stopped_s |=> flags == 7'h00)
    else $error("warning flag set while stopped");
  ref_gate_a: assert property (local_ref_s |=> flags[5:4] == 2'h0)
    else $error("reference warning without remote reference");
  arm_gate_a: assert property ($rose(|flags) |-> $past(run_i, 2) || $past(run_i, 3))
    else $error("warning rose without run");
  trip_arm_a: assert property ($rose(trip_o) |-> $past(run_i, 2) || $past(run_i, 3))
    else $error("trip rose without run");
  trip_hold_a: assert property (trip_o && !trip_clear |=> trip_o)
    else $error("trip dropped without clear");
  cur_excl_a: assert property (!(flags[0] && flags[1]))
    else $error("both current warnings set");
  freq_excl_a: assert property (!(flags[2] && flags[3]))
    else $error("both frequency warnings set");
  ref_excl_a: assert property (!(flags[4] && flags[5]))
    else $error("both reference warnings set");
  rd_idle_a: assert property (!rd_en_i |=> rd_data_o == '0)
    else $error("read data without read");
endmodule
bind dlwm_top dlwm_properties #(.DW(DW), .AW(AW)) dlwm_properties_inst (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
  .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
  .remote_ref_sel_i(remote_ref_sel_i), .run_i(run_i),
  .low_current_warning_o(low_current_warning_o),
  .high_current_warning_o(high_current_warning_o),
  .low_frequency_warning_o(low_frequency_warning_o),
  .high_frequency_warning_o(high_frequency_warning_o),
  .low_reference_warning_o(low_reference_warning_o),
  .high_reference_warning_o(high_reference_warning_o),
  .low_feedback_warning_o(low_feedback_warning_o), .trip_o(trip_o)
);

// ---- verification/dlwm_core_model.sv ----
`timescale 1ns/10ps
module dlwm_core_model
  import dlwm_pkg::*;
#(
  parameter int STEP = 5000
)
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic signed [DLWM_DW-1:0] target_i,
  output logic signed [DLWM_DW-1:0] output_freq_o,
  output logic run_o
);
  // Ramps output frequency toward the reference when started, toward 0 when stopped
  logic signed [DLWM_DW-1:0] goal;
  logic signed [DLWM_DW-1:0] diff;
  assign goal = start_i ? target_i : '0;
  assign diff = goal - output_freq_o;
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      output_freq_o <= '0;
      run_o <= 1'b0;
    end
    else
    begin
      run_o <= start_i;
      if (diff > STEP)
        output_freq_o <= output_freq_o + STEP;
      else if (diff < -STEP)
        output_freq_o <= output_freq_o - STEP;
      else
        output_freq_o <= goal;
    end
  end
endmodule

// ---- verification/dlwm_top_bench.sv ----
`timescale 1ns/10ps
module dlwm_top_bench
  import dlwm_pkg::*;
;
  typedef struct {
    logic [31:0] cur, tgt, rref, fb;
    logic sel;
    logic [6:0] want;
  } dlwm_row_t;
  localparam logic [31:0] C_OK = 32'h00000bb8;
  localparam logic [31:0] F_OK = 32'h0000ea60;
  logic clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, sel = 1'b1, start = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = '0, cur = '0, tgt = '0, rref = '0, fb = '0;
  logic [31:0] rdata, freq;
  logic run, trip, irq;
  logic [1:0] sig, rly;
  wire [6:0] flags;
  int fails = 0, check_count = 0;
  logic [31:0] thr [7] = '{32'h3e8, 32'h1388, 32'h4e20, 32'h186a0, 32'hfffffc18, 32'h3e8, 32'h0};
  dlwm_row_t rows [9] = '{
    '{C_OK, F_OK, 32'h0, 32'h1f4, 1'b1, 7'h00}, '{32'h1f4, F_OK, 32'h0, 32'h1f4, 1'b1, 7'h01},
    '{32'h1770, F_OK, 32'h0, 32'h1f4, 1'b1, 7'h02}, '{C_OK, 32'h2710, 32'h0, 32'h1f4, 1'b1, 7'h04},
    '{C_OK, 32'h1adb0, 32'h0, 32'h1f4, 1'b1, 7'h08}, '{C_OK, F_OK, 32'hfffff830, 32'h1f4, 1'b1, 7'h10},
    '{C_OK, F_OK, 32'h7d0, 32'h1f4, 1'b1, 7'h20}, '{C_OK, F_OK, 32'h7d0, 32'h1f4, 1'b0, 7'h00},
    '{C_OK, F_OK, 32'h0, 32'hfffffffb, 1'b1, 7'h40}};
  dlwm_core_model dlwm_core_model_inst (.ref_clk_i(clk), .rst_n_i(rst_n), .start_i(start),
    .target_i(tgt), .output_freq_o(freq), .run_o(run));
  dlwm_top dlwm_top_inst (.ref_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wr_data_i(wdata),
    .wr_en_i(wr_en), .rd_en_i(rd_en), .rd_data_o(rdata), .motor_current_i(cur),
    .output_freq_i(freq), .freq_reference_i(tgt), .remote_reference_i(rref), .feedback_i(fb),
    .remote_ref_sel_i(sel), .run_i(run), .low_current_warning_o(flags[0]),
    .high_current_warning_o(flags[1]), .low_frequency_warning_o(flags[2]),
    .high_frequency_warning_o(flags[3]), .low_reference_warning_o(flags[4]),
    .high_reference_warning_o(flags[5]), .low_feedback_warning_o(flags[6]),
    .signal_out_o(sig), .relay_out_o(rly), .trip_o(trip), .irq_o(irq));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial
  begin
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    tally_and_finish;
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++)
      rd_chk("threshold reset", OFF_THR_BASE + 8'(4 * i), THR_RST[i]);
    rd_chk("action reset", OFF_CTRL, 32'h1);
    rd_chk("unmapped read", 8'h40, 32'h0);
    wr(OFF_THR_BASE + 8'h04, 32'h1388);
    wr(OFF_THR_BASE, 32'h1770);
    rd_chk("low current clamp", OFF_THR_BASE, 32'h1388);
    for (int i = 0; i < 7; i++)
      wr(OFF_THR_BASE + 8'(4 * i), thr[i]);
    $display("test reset and limits done");
    for (int r = 0; r < 9; r++)
    begin
      @(posedge clk);
      cur <= rows[r].cur;
      tgt <= rows[r].tgt;
      rref <= rows[r].rref;
      fb <= rows[r].fb;
      sel <= rows[r].sel;
      start <= 1'b1;
      wait_n(30);
      chk("row flags", {25'h0, rows[r].want}, {25'h0, flags});
    end
    $display("test rows done");
    @(posedge clk);
    start <= 1'b0;
    cur <= 32'h1f4;
    fb <= 32'h1f4;
    wait_n(5);
    chk("stopped flags", 32'h0, {25'h0, flags});
    wait_n(20);
    @(posedge clk);
    start <= 1'b1;
    wait_n(4);
    chk("ramp up flags", 32'h0, {25'h0, flags});
    wait_n(30);
    chk("armed flags", 32'h1, {25'h0, flags});
    $display("test arming done");
    @(posedge clk);
    fb <= 32'hfffffffb;
    wr(OFF_OUT_SEL, 32'h2117);
    wait_n(5);
    chk("signal out", 32'h3, {30'h0, sig});
    chk("relay out", 32'h1, {30'h0, rly});
    rd_chk("irq status", OFF_IRQ_STAT, 32'h7f);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(OFF_IRQ_MASK, 32'h1);
    wait_n(1);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(OFF_IRQ_STAT, 32'h1);
    wait_n(1);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test routing and irq done");
    wr(OFF_CTRL, 32'h0);
    wait_n(5);
    chk("trip set", 32'h1, {31'h0, trip});
    chk("trip flag", 32'h40, {25'h0, flags});
    rd_chk("status trip", OFF_STATUS, 32'h340);
    @(posedge clk);
    cur <= C_OK;
    wait_n(5);
    chk("trip held", 32'h1, {31'h0, trip});
    wr(OFF_CTRL, 32'h3);
    wait_n(2);
    chk("trip cleared", 32'h0, {31'h0, trip});
    $display("test trip done");
    @(posedge clk);
    cur <= 32'h1f4;
    wait_n(5);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wait_n(1);
    chk("reset flags", 32'h0, {25'h0, flags});
    rd_chk("reset low limit", OFF_THR_BASE, 32'h0);
    wr(OFF_THR_BASE, 32'hfffffc18);
    rd_chk("low current floor", OFF_THR_BASE, 32'h0);
    $display("test mid run reset done");
    tally_and_finish;
  end
endmodule
